/* src/lcs_bit_edit.v */
`timescale 1ns/1ps
`include "lcs_cmd_map.vh"
module lcs_bit_edit (
  // Byte and bit command.
  input wire [7:0] byte_in,
  input wire [7:0] cmd,
  // Edited byte.
  output wire [7:0] byte_out
);
  genvar i;
  // Each lane is replaced only when its index matches the selector.
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_lane
      assign byte_out[i] = (cmd[2:0] == i) ? cmd[`LCS_BIT_SETCLR] :
                           byte_in[i]; // [R21] [R22]
    end
  endgenerate
endmodule

/* src/lcs_cmd_map.vh */
`ifndef LCS_CMD_MAP_VH
`define LCS_CMD_MAP_VH
// Operation
// [R01] Display-mode low nibble zero blanks; bit1 cursor, bit0 blink.
// [R02] Display-mode bit2 enables text layer, bit3 enables graphic layer.
// [R03] Host enables both layers for combined output or attributes.
// [R04] Cursor-pattern low three bits give cursor height minus one.
// [R05] Auto-write or auto-read command enters streaming mode.
// [R06] Host loads the address pointer before auto commands.
// [R07] Streaming advances the address pointer by one per byte.
// [R08] Streaming refuses every command except auto-reset.
// [R09] Auto-reset ends streaming and restores normal decoding.
// [R10] Host polls ready flags between bytes before auto-reset.
// [R11] Single write stores operand then increments, decrements or holds pointer.
// [R12] Single read fetches byte then increments, decrements or holds pointer.
// [R13] Outside streaming host sends one command per byte.
// [R14] Host sets the pointer before single data commands.
// [R15] Screen peek stacks one combined displayed byte for the host.
// [R16] Peek outside graphic area is ignored and sets error flag.
// [R17] Screen copy copies one raster line into the graphic area.
// [R18] Host avoids screen copy while attributes are in use.
// [R19] Host avoids screen copy with dual-scan panels.
// [R20] Peek and copy need software column count equal hardware count.
// [R21] Bit command bit 3 chooses clear or set.
// [R22] Bit command low three bits select exactly one target bit.
// [R23] Hold an address pointer loaded by a dedicated command.
// [R24] Don't-care command bits are ignored while decoding.
// [R25] Bit command is read-modify-write and keeps the pointer.

// ----------------------------------------------------------------------
// Command codes and masks
// ----------------------------------------------------------------------
`define LCS_HI_DISP 4'h9
`define LCS_HI_CURS 5'h14
`define LCS_HI_BIT 4'hf
`define LCS_CMD_AWR 8'hb0
`define LCS_CMD_ARD 8'hb1
`define LCS_CMD_ARST 8'hb2
`define LCS_CMD_WINC 8'hc0
`define LCS_CMD_RINC 8'hc1
`define LCS_CMD_WDEC 8'hc2
`define LCS_CMD_RDEC 8'hc3
`define LCS_CMD_WHLD 8'hc4
`define LCS_CMD_RHLD 8'hc5
`define LCS_CMD_PEEK 8'he0
`define LCS_CMD_COPY 8'he8
`define LCS_CMD_SETPTR 8'h24

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define LCS_BIT_SETCLR 3
`define LCS_BIT_GFX 3
`define LCS_BIT_TXT 2
`define LCS_BIT_CUR 1
`define LCS_BIT_BLK 0
`define LCS_RST_HEIGHT 3'h0
`define LCS_RST_MODE 4'h0
`endif

/* src/lcs_ptr_step.v */
`timescale 1ns/1ps
module lcs_ptr_step #(
  parameter AW = 16
) (
  // Pointer in and step request.
  input wire [AW-1:0] ptr,
  input wire inc,
  input wire dec,
  // Stepped pointer.
  output wire [AW-1:0] ptr_next
);
  // Wraps at the top of RAM; an increment wins if both are asked.
  assign ptr_next = inc ? ptr + {{(AW-1){1'b0}}, 1'b1} :
                    dec ? ptr - {{(AW-1){1'b0}}, 1'b1} : ptr;
endmodule

/* src/lcs_seq.v */
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "lcs_cmd_map.vh"
module lcs_seq #(
  parameter AW = 16,
  parameter COLS = 32
) (
  // Clock, reset, enable.
  input wire ref_clk,
  input wire rst,
  input wire ce,
  // Host command/data port.
  input wire host_cmd_wr,
  input wire host_dat_wr,
  input wire host_dat_rd,
  input wire [7:0] host_wdata,
  input wire [AW-1:0] ptr_load_val,
  output reg [7:0] host_rdata,
  output reg auto_read_ready_flag,
  output reg auto_write_ready_flag,
  output reg peek_copy_error_flag,
  output reg busy,
  // Display settings.
  input wire [AW-1:0] gfx_home,
  input wire [AW-1:0] gfx_size,
  output reg text_en,
  output reg gfx_en,
  output reg cursor_en,
  output reg blink_en,
  output reg [2:0] cursor_height,
  output reg [AW-1:0] ram_address_pointer,
  // External display RAM.
  output reg [AW-1:0] ram_addr,
  output reg ram_we,
  output reg ram_re,
  output reg [7:0] ram_wdata,
  input wire [7:0] ram_rdata,
  input wire [7:0] disp_rdata
);
  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_WOP = 3'h1;
  localparam [2:0] S_RD = 3'h2;
  localparam [2:0] S_BRD = 3'h3;
  localparam [2:0] S_BWR = 3'h4;
  localparam [2:0] S_CRD = 3'h5;
  localparam [2:0] S_CWR = 3'h6;

  reg [2:0] st_q;
  reg [7:0] cmd_q;
  reg [1:0] auto_q;
  reg [7:0] cnt_q;
  reg [7:0] copy_q;
  wire [AW-1:0] ptr_inc;
  wire [AW-1:0] ptr_dec;
  wire [7:0] bit_res;

  // Pointer adders shared by every stepping command.
  lcs_ptr_step #(.AW(AW)) u_inc (
    .ptr(ram_address_pointer),
    .inc(1'b1),
    .dec(1'b0),
    .ptr_next(ptr_inc)
  );
  lcs_ptr_step #(.AW(AW)) u_dec (
    .ptr(ram_address_pointer),
    .inc(1'b0),
    .dec(1'b1),
    .ptr_next(ptr_dec)
  );
  lcs_bit_edit u_bit (
    .byte_in(ram_rdata),
    .cmd(cmd_q),
    .byte_out(bit_res)
  );

  // True when the pointer lies inside the graphic area.
  function in_gfx;
    input [AW-1:0] p;
    input [AW-1:0] home;
    input [AW-1:0] size;
    begin
      in_gfx = (p >= home) && ((p - home) < size);
    end
  endfunction

  // Last byte index of a copied line, cut to the counter width on purpose.
  localparam [31:0] COPY_LAST_W = COLS - 1;
  wire [7:0] copy_last = COPY_LAST_W[7:0];

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  // Outputs are all registered; RAM strobes are one-cycle pulses.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      cmd_q <= 8'h00;
      auto_q <= 2'h0;
      cnt_q <= 8'h00;
      copy_q <= 8'h00;
      host_rdata <= 8'h00;
      auto_read_ready_flag <= 1'b0;
      auto_write_ready_flag <= 1'b0;
      peek_copy_error_flag <= 1'b0;
      busy <= 1'b0;
      text_en <= 1'b0;
      gfx_en <= 1'b0;
      cursor_en <= 1'b0;
      blink_en <= 1'b0;
      cursor_height <= `LCS_RST_HEIGHT;
      ram_address_pointer <= {AW{1'b0}};
      ram_addr <= {AW{1'b0}};
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      ram_wdata <= 8'h00;
    end else if (ce) begin
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      case (st_q)
        S_IDLE: begin
          busy <= 1'b0;
          if (auto_q != 2'h0) begin
            // Streaming: only data moves, only auto-reset is decoded.
            if (host_cmd_wr && host_wdata == `LCS_CMD_ARST) begin
              auto_q <= 2'h0; // [R09]
              auto_read_ready_flag <= 1'b0;
              auto_write_ready_flag <= 1'b0;
            end else if (auto_q[0] && host_dat_wr) begin
              ram_addr <= ram_address_pointer;
              ram_wdata <= host_wdata;
              ram_we <= 1'b1; // [R05]
              ram_address_pointer <= ptr_inc; // [R07]
            end else if (auto_q[1] && host_dat_rd) begin
              ram_addr <= ram_address_pointer;
              ram_re <= 1'b1;
              cmd_q <= `LCS_CMD_RINC;
              auto_read_ready_flag <= 1'b0;
              busy <= 1'b1;
              st_q <= S_RD;
            end
            // Any other command byte is dropped here. [R08]
          end else if (host_cmd_wr) begin
            cmd_q <= host_wdata;
            peek_copy_error_flag <= 1'b0;
            // Don't-care bits never reach the compares below. [R24]
            if (host_wdata[7:4] == `LCS_HI_DISP) begin
              text_en <= host_wdata[`LCS_BIT_TXT]; // [R02]
              gfx_en <= host_wdata[`LCS_BIT_GFX]; // [R02]
              cursor_en <= host_wdata[`LCS_BIT_CUR]; // [R01]
              blink_en <= host_wdata[`LCS_BIT_CUR] &
                          host_wdata[`LCS_BIT_BLK]; // [R01]
            end else if (host_wdata[7:3] == `LCS_HI_CURS) begin
              cursor_height <= host_wdata[2:0]; // [R04]
            end else if (host_wdata[7:4] == `LCS_HI_BIT) begin
              ram_addr <= ram_address_pointer;
              ram_re <= 1'b1; // [R25]
              busy <= 1'b1;
              st_q <= S_BRD;
            end else begin
              case (host_wdata)
                `LCS_CMD_SETPTR: begin
                  ram_address_pointer <= ptr_load_val; // [R23]
                end
                `LCS_CMD_AWR: begin
                  auto_q <= 2'h1; // [R05]
                  auto_write_ready_flag <= 1'b1;
                end
                `LCS_CMD_ARD: begin
                  auto_q <= 2'h2; // [R05]
                  auto_read_ready_flag <= 1'b1;
                end
                `LCS_CMD_WINC, `LCS_CMD_WDEC, `LCS_CMD_WHLD: begin
                  busy <= 1'b1;
                  st_q <= S_WOP;
                end
                `LCS_CMD_RINC, `LCS_CMD_RDEC, `LCS_CMD_RHLD,
                `LCS_CMD_PEEK: begin
                  if (host_wdata == `LCS_CMD_PEEK &&
                      !in_gfx(ram_address_pointer, gfx_home,
                              gfx_size)) begin
                    peek_copy_error_flag <= 1'b1; // [R16]
                  end else begin
                    ram_addr <= ram_address_pointer;
                    ram_re <= 1'b1; // [R12] [R15]
                    busy <= 1'b1;
                    st_q <= S_RD;
                  end
                end
                `LCS_CMD_COPY: begin
                  cnt_q <= 8'h00;
                  copy_q <= 8'h00;
                  busy <= 1'b1;
                  st_q <= S_CRD; // [R17]
                end
                default: begin
                end
              endcase
            end
          end
        end
        S_WOP: begin
          // Operand byte completes the single write.
          if (host_dat_wr) begin
            ram_addr <= ram_address_pointer;
            ram_wdata <= host_wdata;
            ram_we <= 1'b1; // [R11]
            if (cmd_q == `LCS_CMD_WINC)
              ram_address_pointer <= ptr_inc; // [R11]
            else if (cmd_q == `LCS_CMD_WDEC)
              ram_address_pointer <= ptr_dec; // [R11]
            busy <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_RD: begin
          // RAM data stand in the cycle after the strobe, so wait it out.
          if (!ram_re) begin
            if (cmd_q == `LCS_CMD_PEEK)
              host_rdata <= disp_rdata; // [R15]
            else
              host_rdata <= ram_rdata; // [R12]
            if (cmd_q == `LCS_CMD_RINC)
              ram_address_pointer <= ptr_inc; // [R07] [R12]
            else if (cmd_q == `LCS_CMD_RDEC)
              ram_address_pointer <= ptr_dec; // [R12]
            if (auto_q[1])
              auto_read_ready_flag <= 1'b1;
            busy <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_BRD: begin
          // Same read latency as a plain read before the edited byte.
          if (!ram_re) begin
            ram_addr <= ram_address_pointer;
            ram_wdata <= bit_res; // [R22]
            ram_we <= 1'b1; // [R25]
            busy <= 1'b0;
            st_q <= S_IDLE;
          end
        end
        S_CRD: begin
          // Read displayed byte of the line at the source position.
          ram_addr <= ram_address_pointer + {{(AW-8){1'b0}}, cnt_q};
          ram_re <= 1'b1;
          st_q <= S_CWR;
        end
        S_CWR: begin
          if (!ram_re) begin
            ram_addr <= ram_address_pointer + {{(AW-8){1'b0}}, cnt_q};
            ram_wdata <= disp_rdata;
            ram_we <= 1'b1; // [R17]
            if (cnt_q == copy_last) begin
              busy <= 1'b0;
              st_q <= S_IDLE;
            end else begin
              cnt_q <= cnt_q + 8'h01;
              st_q <= S_CRD;
            end
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* verif/lcd_command_sequencer_test.sv */
`timescale 1ns/1ps
module lcd_command_sequencer_test;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg host_cmd_wr = 1'b0;
  reg host_dat_wr = 1'b0;
  reg host_dat_rd = 1'b0;
  reg [7:0] host_wdata = 8'h00;
  reg [7:0] ptr_load_val = 8'h00;
  reg [7:0] gfx_home = 8'h40;
  reg [7:0] gfx_size = 8'h40;
  wire [7:0] host_rdata, ram_rdata, disp_rdata, ram_wdata;
  wire [7:0] ram_address_pointer, ram_addr;
  wire [2:0] cursor_height;
  wire auto_read_ready_flag, auto_write_ready_flag, peek_copy_error_flag;
  wire busy, text_en, gfx_en, cursor_en, blink_en, ram_we, ram_re;
  reg [7:0] sh [0:255];
  reg [7:0] p, q, d, c;
  integer n_errors = 0;
  integer checks = 0;
  integer i, j, rnd;
  // 50 MHz clock.
  always #10 ref_clk = ~ref_clk;
  lcs_seq #(.AW(8), .COLS(4)) DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .host_cmd_wr(host_cmd_wr), .host_dat_wr(host_dat_wr),
    .host_dat_rd(host_dat_rd), .host_wdata(host_wdata),
    .ptr_load_val(ptr_load_val), .host_rdata(host_rdata),
    .auto_read_ready_flag(auto_read_ready_flag),
    .auto_write_ready_flag(auto_write_ready_flag),
    .peek_copy_error_flag(peek_copy_error_flag), .busy(busy),
    .gfx_home(gfx_home), .gfx_size(gfx_size), .text_en(text_en),
    .gfx_en(gfx_en), .cursor_en(cursor_en), .blink_en(blink_en),
    .cursor_height(cursor_height), .ram_address_pointer(ram_address_pointer),
    .ram_addr(ram_addr), .ram_we(ram_we), .ram_re(ram_re),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .disp_rdata(disp_rdata));
  lcs_ram_model #(.AW(8)) u_ram (.ref_clk(ref_clk), .ram_addr(ram_addr),
    .ram_we(ram_we), .ram_re(ram_re), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .disp_rdata(disp_rdata));
  // Byte after a single bit edit.
  function [7:0] bitx(input [7:0] b, input [7:0] k);
    begin
      bitx = b;
      bitx[k[2:0]] = k[3];
    end
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("mismatch %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Bounded wait: 0 busy low, 1 write ready, 2 read ready.
  task wt(input [1:0] s);
    integer n;
    begin
      n = 0;
      #1;
      while (n < 64 && (s == 0 ? busy !== 1'b0 : s == 1 ?
             auto_write_ready_flag !== 1'b1 : auto_read_ready_flag !== 1'b1)) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      if (n == 64) n_errors = n_errors + 1;
    end
  endtask
  // One strobe cycle: 0 command, 1 data write, 2 data read; read data
  // stand two cycles after the request.
  task send(input [1:0] k, input [7:0] b);
    begin
      @(posedge ref_clk);
      host_cmd_wr <= (k == 2'd0);
      host_dat_wr <= (k == 2'd1);
      host_dat_rd <= (k == 2'd2);
      host_wdata <= b;
      @(posedge ref_clk);
      host_cmd_wr <= 1'b0;
      host_dat_wr <= 1'b0;
      host_dat_rd <= 1'b0;
      // A single-write command stays busy until its operand arrives.
      if (!(k == 2'd0 && (b == 8'hc0 || b == 8'hc2 || b == 8'hc4)))
        wt(0);
      repeat (2) @(posedge ref_clk);
    end
  endtask
  task setp(input [7:0] a);
    begin
      ptr_load_val <= a;
      send(0, 8'h24);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Watchdog well beyond the length of the sequence.
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors = n_errors + 1;
    summarize;
  end
  initial begin
    rnd = $urandom(54833);
    for (i = 0; i < 256; i = i + 1)
      sh[i] = i[7:0] ^ 8'h3c;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk("reset", 16'h0000, {text_en, gfx_en, cursor_en, blink_en,
      cursor_height, ram_address_pointer, busy});
    for (i = 0; i < 16; i = i + 1) begin
      send(0, 8'h90 | i[7:0]);
      chk("mode", {i[3:1], i[1] & i[0]}, {gfx_en, text_en, cursor_en, blink_en});
    end
    for (i = 0; i < 8; i = i + 1) begin
      send(0, 8'ha0 | i[7:0]);
      chk("cursor_height", i[2:0], cursor_height);
    end
    for (i = 0; i < 4; i = i + 1) begin
      p = (i == 0) ? 8'hff : $urandom;
      q = p + 8'h01;
      setp(p);
      chk("pointer", p, ram_address_pointer);
      d = $urandom;
      send(0, 8'hc0);
      send(1, d);
      sh[p] = d;
      chk("pointer", q, ram_address_pointer);
      d = $urandom;
      send(0, 8'hc2);
      send(1, d);
      sh[q] = d;
      chk("pointer", p, ram_address_pointer);
      d = $urandom;
      send(0, 8'hc4);
      send(1, d);
      sh[p] = d;
      chk("pointer", p, ram_address_pointer);
      send(0, 8'hc5);
      chk("host_rdata", {sh[p], p}, {host_rdata, ram_address_pointer});
      send(0, 8'hc1);
      chk("host_rdata", {sh[p], q}, {host_rdata, ram_address_pointer});
      send(0, 8'hc3);
      chk("host_rdata", {sh[q], p}, {host_rdata, ram_address_pointer});
    end
    p = $urandom;
    setp(p);
    send(0, 8'hb0);
    for (j = 0; j < 4; j = j + 1) begin
      wt(1);
      d = $urandom;
      send(1, d);
      sh[p + j[7:0]] = d;
      send(0, 8'h90);
      chk("text_en", 1'b1, text_en);
    end
    wt(1);
    send(0, 8'hb2);
    q = p + 8'h04;
    chk("pointer", q, ram_address_pointer);
    send(0, 8'h94);
    chk("gfx_en", 1'b0, gfx_en);
    setp(p);
    send(0, 8'hb1);
    for (j = 0; j < 4; j = j + 1) begin
      wt(2);
      send(2, 8'h00);
      chk("host_rdata", sh[p + j[7:0]], host_rdata);
    end
    wt(2);
    send(0, 8'hb2);
    for (i = 0; i < 4; i = i + 1) begin
      p = (i < 2) ? 8'h3f + i : 8'h7d + i;
      setp(p);
      send(0, 8'he0);
      chk("peek_copy_error_flag", i % 3 == 0, peek_copy_error_flag);
      if (i % 3 != 0) chk("host_rdata", {~sh[p]}, host_rdata);
    end
    // Copy writes each displayed byte of the line back over its source.
    p = $urandom;
    setp(p);
    send(0, 8'he8);
    for (j = 0; j < 4; j = j + 1)
      sh[p + j[7:0]] = ~sh[p + j[7:0]];
    chk("pointer", p, ram_address_pointer);
    for (j = 0; j < 4; j = j + 1) begin
      send(0, 8'hc1);
      chk("host_rdata", sh[p + j[7:0]], host_rdata);
    end
    for (i = 0; i < 8; i = i + 1) begin
      p = $urandom;
      c = 8'hf0 | ($urandom & 8'h0f);
      setp(p);
      send(0, c);
      chk("pointer", p, ram_address_pointer);
      sh[p] = bitx(sh[p], c);
      send(0, 8'hc5);
      chk("host_rdata", sh[p], host_rdata);
    end
    summarize;
  end
endmodule

/* verif/lcs_ram_model.sv */
`timescale 1ns/1ps
module lcs_ram_model #(
  parameter AW = 8
) (
  // Clock.
  input wire ref_clk,
  // Memory request from the sequencer.
  input wire [AW-1:0] ram_addr,
  input wire ram_we,
  input wire ram_re,
  input wire [7:0] ram_wdata,
  // Read data and displayed byte.
  output reg [7:0] ram_rdata,
  output reg [7:0] disp_rdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  integer i;
  // Known start pattern, so every byte can be predicted.
  initial begin
    for (i = 0; i < (1 << AW); i = i + 1)
      mem[i] = i[7:0] ^ 8'h3c;
    ram_rdata = 8'h00;
    disp_rdata = 8'h00;
  end
  // Data stand one cycle only; otherwise the lines toggle, so that a late
  // sample never matches by accident. Displayed byte is the inverse.
  always @(posedge ref_clk) begin
    if (ram_we)
      mem[ram_addr] <= ram_wdata;
    ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
    disp_rdata <= ram_re ? ~mem[ram_addr] : ~disp_rdata;
  end
endmodule

/* verif/lcs_seq_props.sv */
`timescale 1ns/1ps
module lcs_seq_props #(
  parameter AW = 16,
  parameter COLS = 32
) (
  // Clock and control.
  input wire ref_clk,
  input wire rst,
  input wire ce,
  // Host port.
  input wire host_cmd_wr,
  input wire host_dat_wr,
  input wire [7:0] host_wdata,
  input wire [AW-1:0] ptr_load_val,
  input wire peek_copy_error_flag,
  input wire busy,
  // Display settings.
  input wire [AW-1:0] gfx_home,
  input wire [AW-1:0] gfx_size,
  input wire text_en,
  input wire gfx_en,
  input wire cursor_en,
  input wire blink_en,
  input wire [2:0] cursor_height,
  input wire [AW-1:0] ram_address_pointer,
  // Display RAM.
  input wire [AW-1:0] ram_addr,
  input wire ram_we,
  input wire ram_re,
  input wire [7:0] ram_wdata
);
  reg strm_q;
  reg wop_q;
  // A command counts only when the sequencer is free to take it.
  wire tk = ce && host_cmd_wr && !busy;
  wire nk = tk && !strm_q;
  wire [AW:0] lim = {1'b0, gfx_home} + {1'b0, gfx_size};
  wire outa = ram_address_pointer < gfx_home || {1'b0, ram_address_pointer} >= lim;
  // Streaming and operand-wait state rebuilt from port traffic alone.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strm_q <= 1'b0;
      wop_q <= 1'b0;
    end else begin
      if (tk && host_wdata inside {8'hb0, 8'hb1})
        strm_q <= 1'b1;
      if (tk && host_wdata == 8'hb2)
        strm_q <= 1'b0;
      if (ce && host_dat_wr)
        wop_q <= 1'b0;
      else if (nk && host_wdata inside {8'hc0, 8'hc2, 8'hc4})
        wop_q <= 1'b1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_DISP: assert property (nk && host_wdata[7:4] == 4'h9 |=>
    text_en == $past(host_wdata[2]) && gfx_en == $past(host_wdata[3]) &&
    cursor_en == $past(host_wdata[1]) &&
    blink_en == $past(host_wdata[1] && host_wdata[0])) else $error("display mode");
  AST_CURS: assert property (nk && host_wdata[7:3] == 5'h14 |=>
    cursor_height == $past(host_wdata[2:0])) else $error("cursor height");
  AST_REFUSE: assert property (tk && strm_q && host_wdata != 8'hb2 |=>
    $stable({text_en, gfx_en, cursor_en, blink_en, cursor_height}) && !ram_re)
    else $error("command taken in streaming");
  AST_AUTO: assert property (strm_q && ce && host_dat_wr && !busy |=>
    ram_we ##[0:2] ram_address_pointer == ram_addr + 1'b1) else $error("auto");
  AST_SWR: assert property (wop_q && ce && host_dat_wr |=> ram_we &&
    ram_wdata == $past(host_wdata) && ram_addr == $past(ram_address_pointer))
    else $error("single write");
  AST_SRD: assert property (nk && host_wdata inside {8'hc1, 8'hc3, 8'hc5} |=>
    ram_re && busy && ram_addr == $past(ram_address_pointer) ##2 !busy)
    else $error("single read");
  AST_PEEK: assert property (nk && host_wdata == 8'he0 && outa |=>
    !ram_re ##[0:1] peek_copy_error_flag) else $error("peek outside");
  AST_BITPTR: assert property (nk && host_wdata[7:4] == 4'hf |=>
    $stable(ram_address_pointer) [*3]) else $error("bit command moved pointer");
  AST_PTR_LOAD: assert property (nk && host_wdata == 8'h24 |=>
    ram_address_pointer == $past(ptr_load_val)) else $error("pointer load");
  CV_ARST: cover property (tk && strm_q && host_wdata == 8'hb2);
  CV_PEEK: cover property (nk && host_wdata == 8'he0 && !outa);
  CV_WOP: cover property (wop_q && host_dat_wr);
endmodule
bind lcs_seq lcs_seq_props #(.AW(AW), .COLS(COLS)) u_props (.*);
